// ==== vic_ctrl.sv ====
// Function
// R1 - Accept pin, timer, serial and grouped requests.
// R2 - Events set flags regardless of enable; the common group flag is set only by grouped events whose own enable is set.
// R3 - Each source taken only when enabled.
// R4 - Global enable low blocks all interrupts.
// R5 - Acknowledge pushes program counter onto stack.
// R6 - Then load vector address of source.
// R7 - Return instruction pops saved program counter.
// R8 - Entering service clears the global enable.
// R9 - Requests latched while disabled serviced later.
// R10 - Software may re-enable globally for nesting.
// R11 - Full stack blocks any acknowledgement.
// R12 - Requests serviced on next phase-two pulse.
// R13 - Fixed priority ext A highest, group lowest.
// R14 - Vectors 04H, 08H, 0CH, 10H, 14H.
// R15 - Grouped sources share vector 18H.
// R16 - Grouped flags set common group flag.
// R17 - Group service clears only group flag.
// R18 - Software clears individual grouped flags.
// R19 - Group needs global, own and group enables.
// R20 - Vectored source flags clear on service.
// R21 - Software reads, writes, clears flags and enables.
`timescale 1ns/1ps
module vic_ctrl (
   input  wire logic                        clk,
   input  wire logic                        rstn,
   input  wire logic                        ext_irq_pin_a,
   input  wire logic                        ext_irq_pin_b,
   input  wire logic                        peripheral_irq_pin_n,
   input  wire logic                        tmr0_ovf,
   input  wire logic                        tmr1_ovf,
   input  wire logic                        serial_done,
   input  wire logic                        adc_done,
   input  wire logic                        rtc_event,
   input  wire logic                        tbase_event,
   input  wire logic                        phase_two_pulse,
   input  wire logic                        return_from_irq_instr,
   input  wire logic                        stack_full,
   input  wire logic [vic_pkg::PC_W-1:0]    next_instr_pc,
   input  wire logic                        sw_flag_wr,
   input  wire logic [vic_pkg::NUM_SRC-1:0] sw_flag_data,
   input  wire logic                        sw_gflag_wr,
   input  wire logic [vic_pkg::NUM_GRP-1:0] sw_gflag_data,
   input  wire logic                        sw_gie_wr,
   input  wire logic                        sw_gie_data,
   input  wire logic [vic_pkg::NUM_SRC-1:0] src_enable,
   input  wire logic [vic_pkg::NUM_GRP-1:0] grp_enable,
   output logic                             global_irq_enable,
   output logic [vic_pkg::NUM_SRC-1:0]      req_flags,
   output logic [vic_pkg::NUM_GRP-1:0]      grp_flags,
   output logic                             group_request_flag,
   output logic                             stack_push,
   output logic [vic_pkg::PC_W-1:0]         push_pc,
   output logic                             stack_pop,
   output logic                             pc_load,
   output logic [vic_pkg::PC_W-1:0]         pc_vector
);
   import vic_pkg::*;

   // Pin synchronisers: three stages, a change counts when stages two and three agree.
   // Stage one may go metastable and is read only by stage two.
   // A level that flickers between stages two and three leaves the settled level alone.
   logic [2:0] sync_a;             // Pin A history.
   logic [2:0] sync_b;             // Pin B history.
   logic [2:0] sync_p;             // Peripheral pin history.
   logic       lvl_a;              // Settled level of pin A.
   logic       lvl_b;              // Settled level of pin B.
   logic       lvl_p;              // Settled level of peripheral pin.
   logic       next_lvl_a;         // Next settled level of pin A.
   logic       next_lvl_b;         // Next settled level of pin B.
   logic       next_lvl_p;         // Next settled level of peripheral pin.
   logic       ev_a;               // Rising edge event on pin A.
   logic       ev_b;               // Rising edge event on pin B.
   logic       ev_p;               // Falling edge event on peripheral pin.

   // Pin synchroniser and settled-level logic.
   // An edge event lasts one cycle, in the cycle before the settled level moves.
   // Pins A and B trigger on a rise, the peripheral pin on a fall.
   always_comb begin
      next_lvl_a = (sync_a[1] == sync_a[2]) ? sync_a[2] : lvl_a;
      next_lvl_b = (sync_b[1] == sync_b[2]) ? sync_b[2] : lvl_b;
      next_lvl_p = (sync_p[1] == sync_p[2]) ? sync_p[2] : lvl_p;
      ev_a = next_lvl_a & ~lvl_a;
      ev_b = next_lvl_b & ~lvl_b;
      ev_p = ~next_lvl_p & lvl_p;
   end

   // Registers the synchronisers.
   // Pins A and B rest low and the peripheral pin rests high, so no false edge follows reset.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
         sync_p <= RST_PIN_SYNC;
         lvl_a  <= 1'b0;
         lvl_b  <= 1'b0;
         lvl_p  <= 1'b1;
      end else begin
         sync_a <= {sync_a[1:0], ext_irq_pin_a};
         sync_b <= {sync_b[1:0], ext_irq_pin_b};
         sync_p <= {sync_p[1:0], peripheral_irq_pin_n};
         lvl_a  <= next_lvl_a;
         lvl_b  <= next_lvl_b;
         lvl_p  <= next_lvl_p;
      end
   end

   // Flag and enable state.
   // Every flag is a register that software can overwrite and hardware sets or clears.
   logic [NUM_SRC-1:0] next_req_flags;  // Next request flags.
   logic [NUM_GRP-1:0] next_grp_flags;  // Next grouped flags.
   logic               next_gie;        // Next global enable.
   logic [NUM_SRC-1:0] src_events;      // Events of the vectored sources this cycle.
   logic [NUM_GRP-1:0] grp_events;      // Events of grouped sources this cycle.
   logic [NUM_SRC-1:0] eligible;        // Flags that may be taken now.
   logic [NUM_SRC-1:0] grant;           // One-hot winner.
   logic               take;            // Acknowledge happens this cycle.
   logic [PC_W-1:0]    next_vec;        // Vector of the winner.

   // Event, arbitration and flag update logic.
   // A request is taken only on a phase-two pulse, with the global enable set and room
   // on the stack; the lowest numbered eligible flag wins.
   // An event in the same cycle as a clear wins, so no request is lost.
   always_comb begin
      grp_events = '0;
      grp_events[GRP_ADC]    = adc_done;      // R1
      grp_events[GRP_RTC]    = rtc_event;
      grp_events[GRP_TBASE]  = tbase_event;
      grp_events[GRP_PERIPH] = ev_p;
      src_events = '0;
      src_events[SRC_EXT_A]  = ev_a;          // R1
      src_events[SRC_EXT_B]  = ev_b;
      src_events[SRC_TMR0]   = tmr0_ovf;
      src_events[SRC_TMR1]   = tmr1_ovf;
      src_events[SRC_SERIAL] = serial_done;
      // A grouped event sets the common flag only when its own enable is set.
      src_events[SRC_GROUP]  = |(grp_events & grp_enable);  // R16 R19
      // Eligible flags need their own enable; taking also needs global enable, and a full stack blocks all.
      eligible = req_flags & src_enable;      // R3
      take = phase_two_pulse & global_irq_enable & ~stack_full & (|eligible);  // R4 R11 R12
      // Lowest index wins: subtracting one flips the lowest set bit and all below it.
      // The mask keeps only that bit, so the grant is one-hot or zero.
      grant = eligible & ~(eligible - 6'h01);  // R13
      if (!take) begin
         grant = '0;
      end
      next_vec = VEC_GROUP;                    // R15
      unique case (1'b1)
         grant[SRC_EXT_A]:  next_vec = VEC_EXT_A;   // R14
         grant[SRC_EXT_B]:  next_vec = VEC_EXT_B;
         grant[SRC_TMR0]:   next_vec = VEC_TMR0;
         grant[SRC_TMR1]:   next_vec = VEC_TMR1;
         grant[SRC_SERIAL]: next_vec = VEC_SERIAL;
         default:           next_vec = VEC_GROUP;
      endcase
      // Software writes first, hardware clear on service, then events win.
      // Only the winner's own bit is cleared; grouped flags are never cleared by service,
      // which leaves the service routine to find and clear the grouped source.
      next_req_flags = sw_flag_wr ? sw_flag_data : req_flags;  // R21
      next_req_flags = next_req_flags & ~grant;                // R17 R20
      next_req_flags = next_req_flags | src_events;            // R2 R9
      next_grp_flags = sw_gflag_wr ? sw_gflag_data : grp_flags;  // R18 R21
      next_grp_flags = next_grp_flags | grp_events;             // R2
      next_gie = sw_gie_wr ? sw_gie_data : global_irq_enable;   // R10
      if (take) begin
         next_gie = 1'b0;                                       // R8
      end
   end

   // Registers flags, enable and the core handshake outputs.
   // Push and load are one-cycle pulses one edge after the decision; the pushed address
   // and the vector hold their values until the next acknowledge.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         req_flags         <= RST_FLAGS;
         grp_flags         <= RST_GFLAGS;
         global_irq_enable <= 1'b0;
         stack_push        <= 1'b0;
         pc_load           <= 1'b0;
         push_pc           <= '0;
         pc_vector         <= '0;
         stack_pop         <= 1'b0;
      end else begin
         req_flags         <= next_req_flags;
         grp_flags         <= next_grp_flags;
         global_irq_enable <= next_gie;
         stack_push        <= take;                                     // R5
         pc_load           <= take;                                     // R6
         push_pc           <= take ? next_instr_pc : push_pc;           // R5
         pc_vector         <= take ? next_vec : pc_vector;              // R6
         stack_pop         <= return_from_irq_instr;                    // R7
      end
   end

   // The common group flag is the top request flag, read by software as it stands.
   assign group_request_flag = req_flags[SRC_GROUP];  // R16

   // Checks. Every property samples on the rising edge and is off while reset is low.
   // They watch the registered handshake to the core and the flags that software reads,
   // so a failure points at the cycle after the decision that went wrong.
   // Where an event may set a flag again in the cycle of its clear, the check allows it.

   // Entering service must drop the global enable on the very next edge.
   property p_gie_clear;
      @(posedge clk) disable iff (!rstn) take |=> !global_irq_enable;
   endproperty
   a_gie_clear: assert property (p_gie_clear) else $error("enable not cleared"); // R8

   // With the global enable low no acknowledge may follow.
   property p_no_take_gie_low;
      @(posedge clk) disable iff (!rstn) !global_irq_enable |=> !stack_push;
   endproperty
   a_no_take_gie_low: assert property (p_no_take_gie_low) else $error("taken while off"); // R4

   // A full stack holds off the vector load.
   property p_full_block;
      @(posedge clk) disable iff (!rstn) stack_full |=> !pc_load;
   endproperty
   a_full_block: assert property (p_full_block) else $error("taken with full stack"); // R11

   // Acknowledges are only taken on a phase-two pulse.
   property p_t2_only;
      @(posedge clk) disable iff (!rstn) !phase_two_pulse |=> !stack_push;
   endproperty
   a_t2_only: assert property (p_t2_only) else $error("taken off phase pulse"); // R12

   // The push carries the address of the next instruction, together with the load.
   property p_push_pc;
      @(posedge clk) disable iff (!rstn)
         take |=> stack_push && pc_load && push_pc == $past(next_instr_pc);
   endproperty
   a_push_pc: assert property (p_push_pc) else $error("pushed address wrong"); // R5

   // Pin A outranks everything; its flag clears unless a new edge arrives at once.
   property p_ext_a_vec;
      @(posedge clk) disable iff (!rstn)
         take && eligible[SRC_EXT_A] && !ev_a |=>
            pc_vector == VEC_EXT_A && !req_flags[SRC_EXT_A];
   endproperty
   a_ext_a_vec: assert property (p_ext_a_vec) else $error("ext A vector wrong"); // R13

   // Servicing the group alone keeps every grouped flag.
   property p_group_keep;
      @(posedge clk) disable iff (!rstn)
         take && eligible == 6'h20 && !sw_gflag_wr |=>
            pc_vector == VEC_GROUP && grp_flags == ($past(grp_flags) | $past(grp_events));
   endproperty
   a_group_keep: assert property (p_group_keep) else $error("group flags lost"); // R17

   // Group service drops the common flag unless a new enabled grouped event arrives.
   property p_group_clear;
      @(posedge clk) disable iff (!rstn)
         take && eligible == 6'h20 && !src_events[SRC_GROUP] |=> !group_request_flag;
   endproperty
   a_group_clear: assert property (p_group_clear) else $error("group flag kept"); // R17

   // A timer overflow sets its flag whatever the enables.
   property p_flag_set;
      @(posedge clk) disable iff (!rstn) tmr0_ovf |=> req_flags[SRC_TMR0];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("timer flag not set"); // R2

   // A grouped event always sets its own flag, enabled or not.
   property p_grp_flag_set;
      @(posedge clk) disable iff (!rstn) adc_done |=> grp_flags[GRP_ADC];
   endproperty
   a_grp_flag_set: assert property (p_grp_flag_set) else $error("grouped flag not set"); // R2

   // An enabled grouped event raises the common flag on the next edge.
   property p_group_set;
      @(posedge clk) disable iff (!rstn)
         (|(grp_events & grp_enable)) |=> group_request_flag;
   endproperty
   a_group_set: assert property (p_group_set) else $error("group flag not set"); // R16

   // The shared vector is loaded only when global, group and request all stood.
   property p_group_gate;
      @(posedge clk) disable iff (!rstn)
         pc_load && pc_vector == VEC_GROUP |->
            $past(global_irq_enable && src_enable[SRC_GROUP] && req_flags[SRC_GROUP]);
   endproperty
   a_group_gate: assert property (p_group_gate) else $error("group taken ungated"); // R19

   // The vector and the pushed address hold between acknowledges.
   property p_vec_hold;
      @(posedge clk) disable iff (!rstn)
         !stack_push |-> $stable(pc_vector) && $stable(push_pc);
   endproperty
   a_vec_hold: assert property (p_vec_hold) else $error("vector moved"); // R6

   // A return instruction pops the stack one edge later.
   property p_pop;
      @(posedge clk) disable iff (!rstn) return_from_irq_instr |=> stack_pop;
   endproperty
   a_pop: assert property (p_pop) else $error("no pop on return"); // R7

   // Main scenarios: an acknowledge, a group service, a refusal on a full stack,
   // the second of two nested entries and a return.
   c_take: cover property (@(posedge clk) disable iff (!rstn) take);
   c_group: cover property (@(posedge clk) disable iff (!rstn) pc_load && pc_vector == VEC_GROUP);
   c_blocked: cover property (@(posedge clk) disable iff (!rstn)
      stack_full && global_irq_enable && |eligible && phase_two_pulse);
   c_nested: cover property (@(posedge clk) disable iff (!rstn) stack_push && stack_full);
   c_pop: cover property (@(posedge clk) disable iff (!rstn) stack_pop);
endmodule

// ==== vic_pkg.sv ====
package vic_pkg;
   // Source indices of the individually vectored requests, in priority order.
   localparam int SRC_EXT_A   = 0;
   localparam int SRC_EXT_B   = 1;
   localparam int SRC_TMR0    = 2;
   localparam int SRC_TMR1    = 3;
   localparam int SRC_SERIAL  = 4;
   localparam int SRC_GROUP   = 5;
   localparam int NUM_SRC     = 6;
   // Grouped source indices.
   localparam int GRP_ADC     = 0;
   localparam int GRP_RTC     = 1;
   localparam int GRP_TBASE   = 2;
   localparam int GRP_PERIPH  = 3;
   localparam int NUM_GRP     = 4;
   // Widths of the program counter and stack pointer.
   localparam int PC_W        = 16;
   localparam int SP_W        = 4;
   // Vector addresses.
   localparam logic [PC_W-1:0] VEC_EXT_A  = 16'h0004;
   localparam logic [PC_W-1:0] VEC_EXT_B  = 16'h0008;
   localparam logic [PC_W-1:0] VEC_TMR0   = 16'h000c;
   localparam logic [PC_W-1:0] VEC_TMR1   = 16'h0010;
   localparam logic [PC_W-1:0] VEC_SERIAL = 16'h0014;
   localparam logic [PC_W-1:0] VEC_GROUP  = 16'h0018;
   // Reset values.
   localparam logic [NUM_SRC-1:0] RST_FLAGS = 6'h00;
   localparam logic [NUM_GRP-1:0] RST_GFLAGS = 4'h0;
   localparam logic [2:0] RST_PIN_SYNC = 3'h7;
endpackage

// ==== vic_core_model.sv ====
`timescale 1ns/1ps
// Core sequencer and stack as seen by the interrupt controller.
module vic_core_model
   import vic_pkg::*;
#(
   parameter int              DEPTH    = 2,
   parameter logic [PC_W-1:0] START_PC = 16'h0100
)(
   input  wire logic            clk,
   input  wire logic            rstn,
   input  wire logic            stack_push,
   input  wire logic [PC_W-1:0] push_pc,
   input  wire logic            stack_pop,
   input  wire logic            pc_load,
   input  wire logic [PC_W-1:0] pc_vector,
   output logic                 phase_two_pulse,
   output logic                 stack_full,
   output logic [PC_W-1:0]      next_instr_pc
);
   logic [PC_W-1:0] stack [DEPTH]; // Saved return addresses.
   int              sp;            // Count of saved addresses.
   logic [1:0]      phase;         // Machine cycle phase.
   // The sequencer moves on the falling edge, clear of the sampling edge.
   always @(negedge clk or negedge rstn) begin
      if (!rstn) begin
         phase <= 2'h0;
         sp <= 0;
         next_instr_pc <= START_PC;
      end else begin
         phase <= phase + 2'h1;
         if (stack_push && sp < DEPTH) begin
            stack[sp] <= push_pc;
            sp <= sp + 1;
         end
         if (pc_load) next_instr_pc <= pc_vector;
         if (stack_pop && sp > 0) begin
            next_instr_pc <= stack[sp-1];
            sp <= sp - 1;
         end
      end
   end
   assign phase_two_pulse = (phase == 2'h1);
   assign stack_full = (sp == DEPTH);
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
   import vic_pkg::*;
   logic            clk = 1'b0;
   logic            rstn, pin_a, pin_b, pin_n, ret, sw_fw, sw_gw, sw_ew, sw_e, p2_prev;
   logic            gie, gflag, push, pop, load, p2, full;
   logic [5:0]      ev, sw_f, en, flags;
   logic [3:0]      sw_g, gen, gflags;
   logic [PC_W-1:0] ppc, vec, npc;
   logic [31:0]     q[$];
   logic [31:0]     note;
   logic [31:0]     seed = 32'd74845;
   int              fail_count = 0;
   int              compares = 0;
   logic [PC_W-1:0] vt [6] = '{VEC_EXT_A, VEC_EXT_B, VEC_TMR0, VEC_TMR1, VEC_SERIAL, VEC_GROUP};
   // Clock of 50 ns period.
   always #25 clk = ~clk;
   vic_ctrl u_vic_ctrl (.clk(clk), .rstn(rstn), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
      .peripheral_irq_pin_n(pin_n), .tmr0_ovf(ev[0]), .tmr1_ovf(ev[1]), .serial_done(ev[2]),
      .adc_done(ev[3]), .rtc_event(ev[4]), .tbase_event(ev[5]), .phase_two_pulse(p2),
      .return_from_irq_instr(ret), .stack_full(full), .next_instr_pc(npc), .sw_flag_wr(sw_fw),
      .sw_flag_data(sw_f), .sw_gflag_wr(sw_gw), .sw_gflag_data(sw_g), .sw_gie_wr(sw_ew),
      .sw_gie_data(sw_e), .src_enable(en), .grp_enable(gen), .global_irq_enable(gie),
      .req_flags(flags), .grp_flags(gflags), .group_request_flag(gflag), .stack_push(push),
      .push_pc(ppc), .stack_pop(pop), .pc_load(load), .pc_vector(vec));
   vic_core_model u_vic_core_model (.clk(clk), .rstn(rstn), .stack_push(push), .push_pc(ppc),
      .stack_pop(pop), .pc_load(load), .pc_vector(vec), .phase_two_pulse(p2),
      .stack_full(full), .next_instr_pc(npc));
   // Prints the counts and the verdict, then ends the run.
   task automatic conclude();
      $display("fail_count=%0d compares=%0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(logic [31:0] got, logic [31:0] exp, string msg);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // Waits a bounded number of falling edges for push, or for pop, to go high.
   task automatic wait_on(input logic on_pop, input int n, input string msg);
      int i;
      for (i = 0; i < n && (on_pop ? pop : push) !== 1'b1; i++) @(negedge clk);
      if ((on_pop ? pop : push) !== 1'b1) begin
         chk(32'h0, 32'h1, msg);
         conclude();
      end
   endtask
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   task automatic set_gie(logic v);
      sw_ew = 1'b1;
      sw_e = v;
      @(negedge clk);
      sw_ew = 1'b0;
   endtask
   task automatic set_flags(logic [5:0] v);
      sw_fw = 1'b1;
      sw_f = v;
      @(negedge clk);
      sw_fw = 1'b0;
      @(negedge clk);
   endtask
   // Notes the expected push, re-enables globally and waits for the acknowledge.
   task automatic ack(logic [PC_W-1:0] v, logic [PC_W-1:0] pc);
      q.push_back({pc, v});
      set_gie(1'b1);
      wait_on(1'b0, 12, "no acknowledge");
      chk(32'(gie), 32'h0, "global enable after entry");
   endtask
   task automatic do_return();
      ret = 1'b1;
      @(negedge clk);
      ret = 1'b0;
      wait_on(1'b1, 3, "no pop");
      @(negedge clk);
   endtask
   // Compares every acknowledge with the oldest note.
   always @(posedge clk) begin
      if (push === 1'b1) begin
         if (q.size() == 0) chk(32'h1, 32'h0, "unexpected acknowledge");
         else begin
            note = q.pop_front();
            chk({ppc, vec}, note, "pushed pc and vector");
            chk(32'({load, p2_prev}), 32'h3, "load on phase two");
         end
      end
      p2_prev = p2;
   end
   initial begin
      int         k, i;
      logic [5:0] m, f;
      {rstn, pin_a, pin_b, ret, sw_fw, sw_gw, sw_ew, sw_e} = '0;
      pin_n = 1'b1;
      {ev, sw_f, sw_g} = '0;
      en = 6'h3f;
      gen = 4'hf;
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      chk(32'({gie, flags, gflags, push, pop}), 32'h0, "reset state");
      // Every source fires while interrupts are off.
      ev = 6'h3f;
      {pin_a, pin_b, pin_n} = 3'h6;
      @(negedge clk);
      ev = 6'h0;
      repeat (6) @(negedge clk);
      chk(32'({flags, gflags, gflag}), 32'h7ff, "latched");
      for (i = 0; i < 6; i++) begin
         ack(vt[i], 16'h0100);
         chk(32'(flags), (32'h3f << (i + 1)) & 32'h3f, "flag clear");
         do_return();
      end
      chk(32'({gflags, gflag}), 32'h1e, "grouped flags kept");
      sw_gw = 1'b1;
      @(negedge clk);
      sw_gw = 1'b0;
      @(negedge clk);
      chk(32'(gflags), 32'h0, "grouped flags cleared");
      // A grouped event with its enable off sets its own flag only.
      gen = 4'he;
      ev = 6'h08;
      @(negedge clk);
      ev = 6'h0;
      repeat (2) @(negedge clk);
      chk(32'({gflags, gflag}), 32'h2, "group gate");
      sw_gw = 1'b1;
      @(negedge clk);
      sw_gw = 1'b0;
      // Random flags and enables; the lowest set bit of the overlap wins.
      for (k = 0; k < 8; k++) begin
         seed = xs(seed);
         f = seed[5:0];
         en = seed[13:8];
         set_flags(f);
         chk(32'(flags), 32'(f), "flag write");
         sw_g = seed[19:16];
         sw_gw = 1'b1;
         @(negedge clk);
         sw_gw = 1'b0;
         @(negedge clk);
         chk(32'(gflags), 32'(seed[19:16]), "grouped flag write");
         m = f & en;
         if (m == 6'h0) begin
            set_gie(1'b1);
            repeat (8) @(negedge clk);
            chk(32'(gie), 32'h1, "masked source");
            set_gie(1'b0);
         end else begin
            i = 0;
            while (!m[i]) i++;
            ack(vt[i], 16'h0100);
            chk(32'(flags), 32'(f & ~(6'h1 << i)), "flag clear");
            do_return();
         end
      end
      // Nested entries fill the two-deep stack; the next request waits for a pop.
      en = 6'h3f;
      set_flags(6'h0c);
      ack(VEC_TMR0, 16'h0100);
      ack(VEC_TMR1, VEC_TMR0);
      set_flags(6'h10);
      set_gie(1'b1);
      repeat (12) @(negedge clk);
      chk(32'({gie, flags}), 32'h50, "stack full");
      q.push_back({VEC_TMR0, VEC_SERIAL});
      do_return();
      wait_on(1'b0, 12, "no acknowledge after pop");
      @(negedge clk);
      do_return();
      do_return();
      conclude();
   end
endmodule
